// >>> sfdp_table.sv
// Parameter table constants, carrier types and the byte lookup of the basic table
`timescale 1ns/1ns

package sfdp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Table placement
    localparam logic [7:0] TABLE_BASE   = 8'h30;
    localparam int         TABLE_DWORDS = 9;
    localparam logic [7:0] TABLE_LAST   = TABLE_BASE + 8'(4 * TABLE_DWORDS - 1);
    localparam logic [7:0] FILL_BYTE    = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////
    // Byte offsets
    localparam logic [7:0] OFS_CAPS      = 8'h30;
    localparam logic [7:0] OFS_ERASE_OPC = 8'h31;
    localparam logic [7:0] OFS_READ_CAPS = 8'h32;
    localparam logic [7:0] OFS_DENSITY   = 8'h34;
    localparam logic [7:0] OFS_Q144_WAIT = 8'h38;
    localparam logic [7:0] OFS_Q144_OPC  = 8'h39;
    localparam logic [7:0] OFS_Q114_WAIT = 8'h3A;
    localparam logic [7:0] OFS_Q114_OPC  = 8'h3B;
    localparam logic [7:0] OFS_D112_WAIT = 8'h3C;
    localparam logic [7:0] OFS_D112_OPC  = 8'h3D;
    localparam logic [7:0] OFS_D122_WAIT = 8'h3E;
    localparam logic [7:0] OFS_D122_OPC  = 8'h3F;
    localparam logic [7:0] OFS_WIDE_CAPS = 8'h40;
    localparam logic [7:0] OFS_D222_WAIT = 8'h46;
    localparam logic [7:0] OFS_D222_OPC  = 8'h47;
    localparam logic [7:0] OFS_Q444_WAIT = 8'h4A;
    localparam logic [7:0] OFS_Q444_OPC  = 8'h4B;
    localparam logic [7:0] OFS_SECTOR    = 8'h4C;

    ////////////////////////////////////////////////////////////////////////////
    // Field values of bytes 30H and 31H
    localparam logic [1:0] ERASE_SIZE_4K   = 2'b01;
    localparam logic       WRITE_GRAN_64   = 1'b1;
    localparam logic       STATUS_NONVOL   = 1'b0;
    localparam logic       WREN_SEL_50H    = 1'b0;
    localparam logic [2:0] UNUSED_ONES     = 3'b111;
    localparam logic [7:0] ERASE_4K_OPCODE = 8'h20;

    // Field values of byte 32H
    localparam logic       DUAL_OUT_SUP    = 1'b1;
    localparam logic [1:0] ADDR_3BYTE_ONLY = 2'b00;
    localparam logic       DTR_SUP         = 1'b0;
    localparam logic       DUAL_IO_SUP     = 1'b1;
    localparam logic       QUAD_IO_SUP     = 1'b0;
    localparam logic       QUAD_OUT_SUP    = 1'b0;
    localparam logic       UNUSED_ONE      = 1'b1;

    localparam logic [31:0] DENSITY_BITS   = 32'h003FFFFF;

    // Fast read wait-state and mode-bit fields
    localparam logic [4:0] WAIT_NONE       = 5'h00;
    localparam logic [2:0] MODE_NONE       = 3'h0;
    localparam logic [4:0] D112_WAIT       = 5'h08;
    localparam logic [2:0] D122_MODE       = 3'h4;
    localparam logic [7:0] D112_OPCODE     = 8'h3B;
    localparam logic [7:0] D122_OPCODE     = 8'hBB;
    localparam logic       D222_SUP        = 1'b0;
    localparam logic       Q444_SUP        = 1'b0;

    // Sector map, size code then erase opcode for four types
    localparam logic [63:0] SECTOR_MAP     = 64'h8A09_D810_520F_200C;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic       start;
        logic       stop;
        logic       next;
        logic [7:0] addr;
    } read_req_t;

    typedef struct packed {
        logic        valid;
        logic        hit;
        logic [7:0]  data;
        logic [31:0] dword;
    } read_rsp_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_BURST = 2'b10
    } read_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // One byte of the basic table; outside the span reads fill
    function automatic logic [7:0] table_byte(input logic [7:0] addr);
        logic [7:0] rel;
        rel = addr - OFS_SECTOR;
        table_byte = FILL_BYTE;
        case (addr)
            OFS_CAPS:      table_byte = {UNUSED_ONES, WREN_SEL_50H, STATUS_NONVOL,
                                         WRITE_GRAN_64, ERASE_SIZE_4K};
            OFS_ERASE_OPC: table_byte = ERASE_4K_OPCODE;
            OFS_READ_CAPS: table_byte = {UNUSED_ONE, QUAD_OUT_SUP, QUAD_IO_SUP, DUAL_IO_SUP,
                                         DTR_SUP, ADDR_3BYTE_ONLY, DUAL_OUT_SUP};
            OFS_DENSITY,
            OFS_DENSITY + 8'h01,
            OFS_DENSITY + 8'h02,
            OFS_DENSITY + 8'h03: table_byte = DENSITY_BITS[8 * (addr[1:0]) +: 8];
            OFS_Q144_WAIT,
            OFS_Q114_WAIT,
            OFS_D222_WAIT,
            OFS_Q444_WAIT: table_byte = {MODE_NONE, WAIT_NONE};
            OFS_Q144_OPC,
            OFS_Q114_OPC,
            OFS_D222_OPC,
            OFS_Q444_OPC:  table_byte = FILL_BYTE;
            OFS_D112_WAIT: table_byte = {MODE_NONE, D112_WAIT};
            OFS_D112_OPC:  table_byte = D112_OPCODE;
            OFS_D122_WAIT: table_byte = {D122_MODE, WAIT_NONE};
            OFS_D122_OPC:  table_byte = D122_OPCODE;
            OFS_WIDE_CAPS: table_byte = {UNUSED_ONES, Q444_SUP, UNUSED_ONES, D222_SUP};
            default: begin
                if (addr >= OFS_SECTOR && addr <= TABLE_LAST) begin
                    table_byte = SECTOR_MAP[8 * rel[2:0] +: 8];
                end
            end
        endcase
    endfunction : table_byte

endpackage : sfdp_pkg

////////////////////////////////////////////////////////////////////////////////
// Combinational lookup of a byte and its aligned doubleword
module sfdp_byte_table (
    // Lookup address
    input  wire logic [7:0]  addr,
    // Lookup result
    output logic      [7:0]  data,
    output logic      [31:0] dword,
    output logic             hit
);

    always_comb begin
        data  = sfdp_pkg::table_byte(addr);
        hit   = (addr >= sfdp_pkg::TABLE_BASE) && (addr <= sfdp_pkg::TABLE_LAST);
        dword = '0;
        for (int lane = 0; lane < 4; lane++) begin
            dword[8 * lane +: 8] = sfdp_pkg::table_byte({addr[7:2], 2'(lane)});
        end
    end

endmodule : sfdp_byte_table

// >>> sfdp_basic_param_rom.sv
// Read sequencer for the basic discoverable-parameter table, 30H to 53H
`timescale 1ns/1ns

// Behaviour
// - Table starts at byte address 30H.
// - Nine doublewords, 30H-53H, all consistent content.
// - Byte 30H bits 1:0 read 01b.
// - Byte 30H bit 2 reads 1.
// - Byte 30H bits 3,4 read 0.
// - Byte 30H bits 7:5 one; byte E5H.
// - Address bytes field reads 00b, three-byte.
// - Byte 32H reads 91H, dual reads only.
// - Byte 38H 00H, byte 39H FFH.
// - Byte 3AH 00H for quad output.
// - Byte 3CH 08H, byte 3DH 3BH.
// - Byte 3EH 80H, byte 3FH BBH.
// - Byte 46H reads 00H.
module sfdp_basic_param_rom (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    // Read request from the command decoder
    input  wire sfdp_pkg::read_req_t  req,
    // Read answer
    output sfdp_pkg::read_rsp_t       rsp,
    output logic                      busy
);

    ////////////////////////////////////////////////////////////////////////////
    // Burst state
    sfdp_pkg::read_state_t state;
    sfdp_pkg::read_state_t next_state;
    logic [7:0]            pointer;
    logic [7:0]            next_pointer;
    sfdp_pkg::read_rsp_t   next_rsp;
    logic                  next_busy;

    logic [7:0]            look_addr;
    logic [7:0]            look_data;
    logic [31:0]           look_dword;
    logic                  look_hit;
    logic                  take;

    // A start and a read in one cycle read the new address at once
    assign look_addr = req.start ? req.addr : pointer;
    assign take      = req.next && (req.start || state == sfdp_pkg::ST_BURST);

    // Bytes 30H to 53H come from the table, the rest read fill
    sfdp_byte_table u_table (
        .addr  (look_addr),
        .data  (look_data),
        .dword (look_dword),
        .hit   (look_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next values
    always_comb begin
        next_state   = state;
        next_pointer = pointer;
        next_rsp     = '0;
        case (state)
            sfdp_pkg::ST_IDLE: begin
                if (req.start && !req.stop) begin
                    next_state   = sfdp_pkg::ST_BURST;
                    next_pointer = req.addr;
                end
            end
            sfdp_pkg::ST_BURST: begin
                if (req.stop) begin
                    next_state = sfdp_pkg::ST_IDLE;
                end else if (req.start) begin
                    next_pointer = req.addr;
                end
            end
            default: begin
                next_state = sfdp_pkg::ST_IDLE;
            end
        endcase
        // Stop ends the burst; a read in the same cycle is still served
        if (take && next_state != sfdp_pkg::ST_IDLE) begin
            next_pointer = look_addr + 8'h01;
        end
        if (take) begin
            next_rsp.valid = 1'b1;
            next_rsp.hit   = look_hit;
            next_rsp.data  = look_data;
            next_rsp.dword = look_dword;
        end
        next_busy = (next_state == sfdp_pkg::ST_BURST);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state   <= sfdp_pkg::ST_IDLE;
            pointer <= '0;
            rsp     <= '0;
            busy    <= 1'b0;
        end else begin
            state   <= next_state;
            pointer <= next_pointer;
            rsp     <= next_rsp;
            busy    <= next_busy;
        end
    end

endmodule : sfdp_basic_param_rom

// >>> sfdp_basic_param_rom_properties.sv
// Concurrent checks on the parameter table reader ports
`timescale 1ns/1ns
module sfdp_basic_param_rom_properties (
    // Clock and reset
    input wire logic                clock,
    input wire logic                sys_rst,
    // Watched ports
    input wire sfdp_pkg::read_req_t req,
    input wire sfdp_pkg::read_rsp_t rsp,
    input wire logic                busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic [7:0] ptr;
    wire logic [7:0] rd = req.start ? req.addr : ptr;
    // A read beside a start is answered even when a stop comes with it
    wire logic       take = req.next && (req.start || busy);
    // Shadow address so any byte of a burst can be judged, not only the first
    always_ff @(posedge clock) ptr <= sys_rst ? 8'h00 : (take ? rd + 8'h01 : rd);
    sequence taken_at(logic [7:0] a);
        take && rd == a;
    endsequence
    property byte_at(logic [7:0] a, logic [7:0] d);
        taken_at(a) |=> rsp.valid && rsp.hit && rsp.data == d;
    endproperty
    a_caps_byte: assert property (byte_at(8'h30, 8'hE5)) else $error("byte 30 wrong");
    a_read_caps: assert property (byte_at(8'h32, 8'h91)) else $error("byte 32 wrong");
    a_quad_io_wait: assert property (byte_at(8'h38, 8'h00)) else $error("byte 38 wrong");
    a_dual_out_wait: assert property (byte_at(8'h3C, 8'h08)) else $error("byte 3C wrong");
    a_dual_io_wait: assert property (byte_at(8'h3E, 8'h80)) else $error("byte 3E wrong");
    a_wide_caps: assert property (byte_at(8'h40, 8'hEE)) else $error("byte 40 wrong");
    a_wide_wait: assert property (byte_at(8'h46, 8'h00)) else $error("byte 46 wrong");
    a_answer_once: assert property (1'b1 |=> rsp.valid == $past(take)) else $error("answer count wrong");
    a_addr_width: assert property (taken_at(8'h31) |=> rsp.dword[18:17] == 2'b00 && rsp.dword[7:0] == 8'hE5)
        else $error("first dword wrong");
endmodule : sfdp_basic_param_rom_properties

bind sfdp_basic_param_rom sfdp_basic_param_rom_properties chk (.clock(clock), .sys_rst(sys_rst), .req(req),
    .rsp(rsp), .busy(busy));

// >>> sfdp_host_model.sv
// Host-side reader that walks bursts through the table
`timescale 1ns/1ns
module sfdp_host_model (
    // Clock
    input  wire logic           clock,
    // Burst order from the bench
    input  wire logic           go,
    input  wire logic           hold,
    input  wire logic [7:0]     first,
    input  wire logic [7:0]     count,
    // Requests toward the table
    output sfdp_pkg::read_req_t req,
    output logic                active
);
    logic [7:0] left = 8'h00;
    wire logic more = !go && !hold && left > 8'h01;
    initial req = '0;
    assign active = left > 8'h01;
    // Address only matters with start, so it toggles to expose stale use
    always @(posedge clock) begin
        req.start <= go;
        req.next  <= go || more;
        req.stop  <= more && left == 8'h02;
        req.addr  <= go ? first : ~req.addr;
        left      <= go ? count : left - 8'(more);
    end
endmodule : sfdp_host_model

// >>> sfdp_basic_param_rom_test.sv
// Self-checking bench for the basic parameter table reader
`timescale 1ns/1ns
module sfdp_basic_param_rom_test;
    localparam logic [287:0] EXP = 288'h8A09D810_520F200C_FF00FFFF_FF00FFFF_FFFFFFEE_BB803B08_FF00FF00_003FFFFF_FF9120E5;
    logic                clock = 1'b0;
    logic                sys_rst = 1'b1;
    logic                go = 1'b0;
    logic                hold = 1'b0;
    logic [7:0]          first = 8'h30;
    logic [7:0]          count = 8'h02;
    logic                busy;
    sfdp_pkg::read_req_t req;
    sfdp_pkg::read_rsp_t rsp;
    sfdp_pkg::read_rsp_t got[$];
    int                  bad_count = 0;
    int                  total_checks = 0;
    initial begin
        forever #5 clock = ~clock;
    end
    sfdp_host_model host (.clock(clock), .go(go), .hold(hold), .first(first), .count(count), .req(req), .active());
    sfdp_basic_param_rom dut (.clock(clock), .sys_rst(sys_rst), .req(req), .rsp(rsp), .busy(busy));
    always @(posedge clock) if (rsp.valid === 1'b1) got.push_back(rsp);

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t byte %h want %h", $time, g, e);
        end
    endtask : cmp8
    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t word %h want %h", $time, g, e);
        end
    endtask : cmp32
    // Bursts are two bytes or more: a count of one gets no stop from the host, so the burst stays open
    task automatic burst(input logic [7:0] a, input logic [7:0] n, input logic slow);
        int k;
        got.delete();
        first <= a;
        count <= n;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        #1;
        for (k = 0; k < 300 && got.size() < int'(n); k++) begin
            @(posedge clock);
            hold <= slow & ~hold;
            #1;
            if (k == 0) cmp8({7'h00, busy}, 8'h01);
        end
        if (k == 300) begin
            bad_count++;
            tally_and_finish();
        end
        repeat (3) @(posedge clock);
        cmp32(32'(got.size()), {24'h000000, n});
        cmp8({7'h00, busy}, 8'h00);
    endtask : burst

    ////////////////////////////////////////////////////////////////////////////
    task automatic sweep;
        burst(8'h30, 8'h24, 1'b0);
        for (int i = 0; i < 36; i++) begin
            cmp8(got[i].data, EXP[8*i +: 8]);
            cmp8({7'h00, got[i].hit}, 8'h01);
            cmp32(got[i].dword, EXP[32*(i/4) +: 32]);
        end
        cmp8(got[0].data & 8'h03, 8'h01);
        cmp8(got[0].data & 8'h04, 8'h04);
        cmp8(got[0].data & 8'h18, 8'h00);
        cmp8(got[1].data, 8'h20);
        cmp8(got[3].data, 8'hFF);
        cmp8(got[9].data, 8'hFF);
        cmp8(got[10].data, 8'h00);
        cmp8(got[13].data, 8'h3B);
        cmp8(got[15].data, 8'hBB);
    endtask : sweep
    task automatic tail_slow;
        burst(8'h41, 8'h06, 1'b1);
        for (int i = 0; i < 5; i++) cmp8(got[i].data, 8'hFF);
        cmp8(got[5].data, 8'h00);
    endtask : tail_slow
    task automatic span_edge;
        burst(8'h2F, 8'h02, 1'b0);
        cmp8(got[0].data, 8'hFF);
        cmp8({7'h00, got[0].hit}, 8'h00);
        cmp8(got[1].data, 8'hE5);
        cmp8({7'h00, got[1].hit}, 8'h01);
    endtask : span_edge

    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        sweep();
        tail_slow();
        span_edge();
        tally_and_finish();
    end
endmodule : sfdp_basic_param_rom_test
